/* File: core/sse_exec.sv */
// Execution core for literal/file subtract, nibble exchange and power-down
`timescale 1ns/100ps
// Function
// (RULE_01) Literal subtract computes literal minus accumulator and stores it in the accumulator.
// (RULE_02) Literal subtract is decoded from top opcode bits 11110x, low byte is the literal.
// (RULE_03) Literal subtract updates only carry, digit carry and zero flags.
// (RULE_04) A positive subtraction result sets carry as an inverted borrow.
// (RULE_05) A zero subtraction result sets carry and the zero flag.
// (RULE_06) A negative result clears carry and the stored value wraps modulo 256.
// (RULE_07) Literal subtract takes one cycle: decode, read, process, write accumulator in Q4.
// (RULE_08) File subtract (000010) computes file minus accumulator, dest bit picks target.
// (RULE_09) Nibble exchange (001110) swaps the nibbles and leaves all flags unchanged.
// (RULE_10) Nibble exchange dest 0 writes the accumulator, dest 1 writes the file register.
// (RULE_11) Power-down takes one cycle: decode in Q1, idle Q2 and Q3, enter power-down in Q4.
// (RULE_12) Power-down clears watchdog and prescaler, sets time-out, clears power-down bit.
// (RULE_13) Both subtracts set digit carry when no borrow leaves bit 3, else clear it.
module sse_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction input, sampled in Q1
  input wire logic [sse_pkg::INSN_W-1:0] insn,
  // Wake request releases power-down
  input wire logic wake,
  // Phase and state
  output logic [1:0] phase,
  output logic [sse_pkg::DATA_W-1:0] acc,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic time_out_status_bit,
  output logic power_down_status_bit,
  output logic osc_stopped,
  output logic [sse_pkg::WDT_W-1:0] watchdog_counter,
  output logic [sse_pkg::PRE_W-1:0] wdt_prescaler,
  // Debug write-back of file register
  output logic file_wr_strobe,
  output logic [sse_pkg::ADDR_W-1:0] file_wr_addr,
  output logic [sse_pkg::DATA_W-1:0] file_wr_data
);
  import sse_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  sse_phase_t phase_reg;
  sse_phase_t phase_next;
  sse_op_t op_reg;
  sse_op_t op_next;
  logic [INSN_W-1:0] insn_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] operand_reg;
  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] result_next;
  logic c_res_reg;
  logic dc_res_reg;
  logic c_res_next;
  logic dc_res_next;
  logic c_reg;
  logic dc_reg;
  logic z_reg;
  logic to_reg;
  logic pd_reg;
  logic sleep_reg;
  logic [WDT_W-1:0] wdt_reg;
  logic [PRE_W-1:0] pre_reg;
  logic fw_strobe_reg;
  logic [ADDR_W-1:0] fw_addr_reg;
  logic [DATA_W-1:0] fw_data_reg;
  logic [DATA_W-1:0] file_rd_data;
  logic dest_file;
  logic [DATA_W:0] diff_wide;
  logic [NIB_W:0] diff_low;
  logic wr_file;
  logic wr_acc;
  logic wake_meta_reg;
  logic wake_sync_reg;

  assign dest_file = insn_reg[DEST_BIT];

  // ****************************************
  // File register memory
  // ****************************************
  sse_regfile u_regfile (
    .clk(clk),
    .reset(reset),
    .rd_addr(insn[ADDR_W-1:0]),
    .rd_data(file_rd_data),
    .wr_en(wr_file),
    .wr_addr(insn_reg[ADDR_W-1:0]),
    .wr_data(result_reg)
  );

  // ****************************************
  // Wake synchroniser
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= wake;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // ****************************************
  // Quarter phase sequencer
  // ****************************************
  always_comb begin
    case (phase_reg)
      SSE_Q1: phase_next = SSE_Q2;
      SSE_Q2: phase_next = SSE_Q3;
      SSE_Q3: phase_next = SSE_Q4;
      SSE_Q4: phase_next = SSE_Q1;
      default: phase_next = SSE_Q1;
    endcase
  end

  // Phase holds in Q1 while stopped, so a fresh word is decoded after wake
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_reg <= SSE_Q1;
    end else if (!sleep_reg) begin
      phase_reg <= phase_next;
    end
  end

  // ****************************************
  // Decode in Q1
  // ****************************************
  always_comb begin
    if (insn[OPC_HI:OPC_LO+1] == OPC_LITERAL_MINUS_ACC_HI5) begin
      op_next = SSE_OP_LIT_SUB; // RULE_02
    end else if (insn[OPC_HI:OPC_LO] == OPC_FILE_MINUS_ACC) begin
      op_next = SSE_OP_FILE_SUB; // RULE_08
    end else if (insn[OPC_HI:OPC_LO] == OPC_NIBBLE_EXCHANGE) begin
      op_next = SSE_OP_SWAP; // RULE_09
    end else if (insn == INSN_POWER_DOWN) begin
      op_next = SSE_OP_SLEEP; // RULE_11
    end else begin
      op_next = SSE_OP_NONE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_reg <= SSE_OP_NONE;
      insn_reg <= {INSN_W{1'b0}};
    end else if (phase_reg == SSE_Q1 && !sleep_reg) begin
      op_reg <= op_next;
      insn_reg <= insn;
    end
  end

  // ****************************************
  // Q2 operand read
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      operand_reg <= DATA_ZERO;
    end else if (phase_reg == SSE_Q2) begin
      if (op_reg == SSE_OP_LIT_SUB) begin
        operand_reg <= insn_reg[DATA_W-1:0]; // RULE_07
      end else begin
        operand_reg <= file_rd_data;
      end
    end
  end

  // ****************************************
  // Q3 processing
  // ****************************************
  assign diff_wide = {1'b0, operand_reg} - {1'b0, acc_reg};
  assign diff_low = {1'b0, operand_reg[NIB_W-1:0]} - {1'b0, acc_reg[NIB_W-1:0]};

  always_comb begin
    result_next = diff_wide[DATA_W-1:0]; // RULE_01 RULE_06
    c_res_next = ~diff_wide[DATA_W]; // RULE_04 RULE_05 RULE_06
    dc_res_next = ~diff_low[NIB_W]; // RULE_13
    if (op_reg == SSE_OP_SWAP) begin
      result_next = {operand_reg[NIB_W-1:0], operand_reg[DATA_W-1:NIB_W]}; // RULE_09
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_reg <= DATA_ZERO;
      c_res_reg <= 1'b0;
      dc_res_reg <= 1'b0;
    end else if (phase_reg == SSE_Q3) begin
      result_reg <= result_next;
      c_res_reg <= c_res_next;
      dc_res_reg <= dc_res_next;
    end
  end

  // ****************************************
  // Q4 write-back
  // ****************************************
  always_comb begin
    wr_acc = 1'b0;
    wr_file = 1'b0;
    if (phase_reg == SSE_Q4) begin
      case (op_reg)
        SSE_OP_LIT_SUB: wr_acc = 1'b1; // RULE_07
        SSE_OP_FILE_SUB, SSE_OP_SWAP: begin
          wr_acc = !dest_file; // RULE_08 RULE_10
          wr_file = dest_file; // RULE_08 RULE_10
        end
        default: begin
          wr_acc = 1'b0;
          wr_file = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_reg <= ACC_RESET;
    end else if (wr_acc) begin
      acc_reg <= result_reg;
    end
  end

  // Subtracts alone touch the flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c_reg <= 1'b0;
      dc_reg <= 1'b0;
      z_reg <= 1'b0;
    end else if (phase_reg == SSE_Q4 &&
                 (op_reg == SSE_OP_LIT_SUB || op_reg == SSE_OP_FILE_SUB)) begin
      c_reg <= c_res_reg; // RULE_03
      dc_reg <= dc_res_reg; // RULE_03
      z_reg <= (result_reg == DATA_ZERO); // RULE_05
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fw_strobe_reg <= 1'b0;
      fw_addr_reg <= {ADDR_W{1'b0}};
      fw_data_reg <= DATA_ZERO;
    end else begin
      fw_strobe_reg <= wr_file;
      if (wr_file) begin
        fw_addr_reg <= insn_reg[ADDR_W-1:0];
        fw_data_reg <= result_reg;
      end
    end
  end

  // ****************************************
  // Power-down entry
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
      sleep_reg <= 1'b0;
    end else if (phase_reg == SSE_Q4 && op_reg == SSE_OP_SLEEP && !sleep_reg) begin
      to_reg <= 1'b1; // RULE_12
      pd_reg <= 1'b0; // RULE_12
      sleep_reg <= 1'b1; // RULE_11
    end else if (sleep_reg && wake_sync_reg) begin
      sleep_reg <= 1'b0;
    end
  end

  // Watchdog runs via prescaler while not stopped; power-down entry clears both, and both hold while stopped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdt_reg <= WDT_CLEAR;
      pre_reg <= PRE_CLEAR;
    end else if (phase_reg == SSE_Q4 && op_reg == SSE_OP_SLEEP && !sleep_reg) begin
      wdt_reg <= WDT_CLEAR; // RULE_12
      pre_reg <= PRE_CLEAR; // RULE_12
    end else if (!sleep_reg) begin
      pre_reg <= pre_reg + 8'h01;
      if (&pre_reg) begin
        wdt_reg <= wdt_reg + 8'h01;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign phase = phase_reg;
  assign acc = acc_reg;
  assign carry_flag = c_reg;
  assign digit_carry_flag = dc_reg;
  assign zero_flag = z_reg;
  assign time_out_status_bit = to_reg;
  assign power_down_status_bit = pd_reg;
  assign osc_stopped = sleep_reg;
  assign watchdog_counter = wdt_reg;
  assign wdt_prescaler = pre_reg;
  assign file_wr_strobe = fw_strobe_reg;
  assign file_wr_addr = fw_addr_reg;
  assign file_wr_data = fw_data_reg;

endmodule : sse_exec

/* File: include/sse_pkg.sv */
// Package: constants, opcodes and phase encoding for the subtract/swap/sleep execution block
package sse_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int INSN_W = 14;
  localparam int ADDR_W = 7;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;

  // ****************************************
  // Instruction fields
  // ****************************************
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int NIB_W = 4;

  // Opcode patterns (top six bits; top five for literal subtract, whole word for power-down)
  localparam logic [5:0] OPC_FILE_MINUS_ACC = 6'h02;
  localparam logic [5:0] OPC_NIBBLE_EXCHANGE = 6'h0E;
  localparam logic [4:0] OPC_LITERAL_MINUS_ACC_HI5 = 5'h1E;
  localparam logic [13:0] INSN_POWER_DOWN = 14'h0063;

  // Reset and clear values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] PRE_CLEAR = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ****************************************
  // Quarter phases and operation codes
  // ****************************************
  typedef enum logic [1:0] {
    SSE_Q1 = 2'b00,
    SSE_Q2 = 2'b01,
    SSE_Q3 = 2'b10,
    SSE_Q4 = 2'b11
  } sse_phase_t;

  typedef enum logic [2:0] {
    SSE_OP_NONE = 3'b000,
    SSE_OP_LIT_SUB = 3'b001,
    SSE_OP_FILE_SUB = 3'b010,
    SSE_OP_SWAP = 3'b011,
    SSE_OP_SLEEP = 3'b100
  } sse_op_t;

endpackage : sse_pkg

/* File: core/sse_regfile.sv */
// File register memory with registered read data
`timescale 1ns/100ps
module sse_regfile (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Read port
  input wire logic [sse_pkg::ADDR_W-1:0] rd_addr,
  output logic [sse_pkg::DATA_W-1:0] rd_data,
  // Write port
  input wire logic wr_en,
  input wire logic [sse_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [sse_pkg::DATA_W-1:0] wr_data
);
  import sse_pkg::*;

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Cleared by reset so file operations never start from unknown contents
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
        mem[i] <= DATA_ZERO;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : sse_regfile

/* File: verif/sse_exec_asserts.sv */
// Checker: timing and result relations of the execution core
`timescale 1ns/100ps
module sse_exec_asserts import sse_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs
  input wire logic [13:0] insn,
  input wire logic wake,
  // Outputs
  input wire logic [1:0] phase,
  input wire logic [7:0] acc,
  input wire logic carry_flag,
  input wire logic digit_carry_flag,
  input wire logic zero_flag,
  input wire logic time_out_status_bit,
  input wire logic power_down_status_bit,
  input wire logic osc_stopped,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] wdt_prescaler,
  input wire logic file_wr_strobe,
  input wire logic [6:0] file_wr_addr,
  input wire logic [7:0] file_wr_data
);
  // ****************************************
  // Word and accumulator seen at the take edge
  // ****************************************
  logic [13:0] lat_insn_reg;
  logic [7:0] lat_acc_reg;
  logic q4, lit, swp, fop;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lat_insn_reg <= 14'h0000;
      lat_acc_reg <= 8'h00;
    end else if (phase == 2'd0 && !osc_stopped) begin
      lat_insn_reg <= insn;
      lat_acc_reg <= acc;
    end
  end
  assign q4 = phase == 2'd3 && !osc_stopped;
  assign lit = q4 && lat_insn_reg[13:9] == OPC_LITERAL_MINUS_ACC_HI5;
  assign swp = q4 && lat_insn_reg[13:8] == OPC_NIBBLE_EXCHANGE;
  assign fop = swp || (q4 && lat_insn_reg[13:8] == OPC_FILE_MINUS_ACC);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_phase_step: assert property (!osc_stopped |=> phase == $past(phase) + 2'd1)
    else $error("phase did not advance");
  chk_lit_result: assert property (lit |=> acc == lat_insn_reg[7:0] - lat_acc_reg)
    else $error("literal subtract result wrong");
  chk_lit_flags: assert property (lit |=> carry_flag == (lat_insn_reg[7:0] >= lat_acc_reg)
    && zero_flag == (lat_insn_reg[7:0] == lat_acc_reg))
    else $error("literal subtract carry or zero wrong");
  chk_digit_carry: assert property (lit |=> digit_carry_flag ==
    (lat_insn_reg[3:0] >= lat_acc_reg[3:0])) else $error("digit carry wrong");
  chk_lit_status: assert property (lit |=> $stable({time_out_status_bit, power_down_status_bit}))
    else $error("status bits changed");
  chk_swap_flags: assert property (swp |=> $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("swap changed a flag");
  chk_file_dest: assert property (fop && lat_insn_reg[7] |=> file_wr_strobe
    && file_wr_addr == lat_insn_reg[6:0] && $stable(acc)) else $error("file write wrong");
  chk_acc_dest: assert property (fop && !lat_insn_reg[7] |=> !file_wr_strobe)
    else $error("file written for dest 0");
  chk_strobe_pulse: assert property (file_wr_strobe |=> !file_wr_strobe)
    else $error("strobe longer than one cycle");
  chk_sleep_entry: assert property (q4 && lat_insn_reg == INSN_POWER_DOWN |=> osc_stopped
    && !power_down_status_bit && time_out_status_bit && watchdog_counter == WDT_CLEAR
    && wdt_prescaler == PRE_CLEAR) else $error("power-down entry wrong");
  chk_stop_freeze: assert property (osc_stopped && !wake |=> $stable(phase) && $stable(acc))
    else $error("core ran while stopped");
endmodule : sse_exec_asserts

bind sse_exec sse_exec_asserts u_chk (.clk(clk), .reset(reset), .insn(insn), .wake(wake),
  .phase(phase), .acc(acc), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
  .zero_flag(zero_flag), .time_out_status_bit(time_out_status_bit),
  .power_down_status_bit(power_down_status_bit), .osc_stopped(osc_stopped),
  .watchdog_counter(watchdog_counter), .wdt_prescaler(wdt_prescaler),
  .file_wr_strobe(file_wr_strobe), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));

/* File: verif/tb_subtract_swap_sleep_exec.sv */
// Testbench: execution core against a behavioural model
`timescale 1ns/100ps
module tb_subtract_swap_sleep_exec;
  import sse_pkg::*;
  logic clk, reset, wake, c, dc, z, to, pd, stp, fs, c_m, dc_m, z_m, pd_m;
  logic [13:0] insn;
  logic [1:0] phase;
  logic [7:0] acc, wdt, pre, fd, acc_m;
  logic [6:0] fa, ad_m;
  logic [7:0] fm[128] = '{default: 8'h00};
  int num_errors, n_compared, n;
  int tbl[$] = '{1, 2, 2, 2, 3, 2, 15, 16, 0, 0, 255, 0, 16, 15};
  logic [13:0] bad[3] = '{14'h0000, 14'h1234, 14'h3A55};
  sse_exec dut (.clk(clk), .reset(reset), .insn(insn), .wake(wake), .phase(phase), .acc(acc),
    .carry_flag(c), .digit_carry_flag(dc), .zero_flag(z), .time_out_status_bit(to),
    .power_down_status_bit(pd), .osc_stopped(stp), .watchdog_counter(wdt),
    .wdt_prescaler(pre), .file_wr_strobe(fs), .file_wr_addr(fa), .file_wr_data(fd));
  // ****************************************
  // Checking and stimulus tasks
  // ****************************************
  task automatic end_sim;
    $display("Mismatches %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({7'h00, got}, {7'h00, exp});
  endtask : cmp_flag
  task automatic exec(input logic [13:0] w);
    insn = w;
    repeat (4) @(posedge clk);
    #1;
  endtask : exec
  task automatic lit(input logic [7:0] kv, input logic b8);
    int d;
    d = int'(kv) - int'(acc_m);
    c_m = d >= 0;
    z_m = d == 0;
    dc_m = kv[3:0] >= acc_m[3:0];
    acc_m = kv - acc_m;
    exec({OPC_LITERAL_MINUS_ACC_HI5, b8, kv});
    cmp_val(acc, acc_m);
    cmp_val({5'h00, c, dc, z}, {5'h00, c_m, dc_m, z_m});
    cmp_val({6'h00, to, pd}, {6'h00, 1'b1, pd_m});
  endtask : lit
  task automatic fop(input logic [5:0] op, input logic d, input logic [6:0] ad);
    logic [7:0] v;
    logic [7:0] r;
    v = fm[ad];
    if (op == OPC_NIBBLE_EXCHANGE) begin
      r = {v[3:0], v[7:4]};
    end else begin
      c_m = v >= acc_m;
      z_m = v == acc_m;
      dc_m = v[3:0] >= acc_m[3:0];
      r = v - acc_m;
    end
    if (d) fm[ad] = r;
    else acc_m = r;
    exec({op, d, ad});
    cmp_flag(fs, d);
    if (d) cmp_val({1'b0, fa}, {1'b0, ad});
    if (d) cmp_val(fd, r);
    cmp_val(acc, acc_m);
    cmp_val({5'h00, c, dc, z}, {5'h00, c_m, dc_m, z_m});
  endtask : fop
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #50000;
    num_errors++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    wake = 1'b0;
    insn = 14'h0000;
    acc_m = ACC_RESET;
    pd_m = 1'b1;
    void'($urandom(61));
    repeat (5) @(posedge clk);
    #1;
    cmp_val({phase, stp, c, dc, z, to, pd}, 8'h03);
    reset = 1'b0;
    for (int i = 0; i < tbl.size(); i += 2) begin
      lit(8'(tbl[i] + int'(acc_m)), 1'b0);
      lit(8'(tbl[i + 1]), i[1]);
    end
    repeat (40) lit(8'($urandom), 1'($urandom));
    foreach (bad[i]) begin
      exec(bad[i]);
      cmp_val({fs, 4'h0, c, dc, z}, {5'h00, c_m, dc_m, z_m});
      cmp_val(acc, acc_m);
    end
    ad_m = 7'($urandom);
    fop(OPC_FILE_MINUS_ACC, 1'b1, ad_m);
    fop(OPC_NIBBLE_EXCHANGE, 1'b1, ad_m);
    fop(OPC_FILE_MINUS_ACC, 1'b1, ad_m);
    lit(8'($urandom), 1'b0);
    exec(INSN_POWER_DOWN);
    pd_m = 1'b0;
    cmp_val({5'h00, stp, pd, to}, 8'h05);
    cmp_val(wdt, WDT_CLEAR);
    cmp_val(pre, PRE_CLEAR);
    insn = {OPC_LITERAL_MINUS_ACC_HI5, 9'h055};
    repeat (6) @(posedge clk);
    #1;
    cmp_val({phase, 6'h00}, 8'h00);
    cmp_val(acc, acc_m);
    insn = 14'h0000;
    wake = 1'b1;
    n = 0;
    while ((stp !== 1'b0 || phase !== 2'd0) && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    wake = 1'b0;
    cmp_flag(stp, 1'b0);
    lit(8'($urandom), 1'b1);
    fop(OPC_NIBBLE_EXCHANGE, 1'b0, ad_m);
    fop(OPC_FILE_MINUS_ACC, 1'b0, ad_m);
    end_sim();
  end
endmodule : tb_subtract_swap_sleep_exec
